// file: design/lpx_pkg.sv
// Shared constants and types for the low-power x16 memory pin interface
`default_nettype none
package lpx_pkg;
   localparam int DATA_W      = 16;
   localparam int BYTE_W      = 8;
   localparam int ADDR_W      = 13;
   localparam int BANK_W      = 2;
   localparam int DIES        = 2;
   localparam int BANKS       = 4;
   localparam int BURST_LEN   = 4;
   localparam int FIFO_DEPTH  = 16;
   localparam int CAS_LAT     = 2;
   localparam int MEM_WORDS   = 64;
   localparam int AP_BIT      = 10;
   localparam logic [1:0] SEL_BASE_MODE = 2'h0;
   localparam logic [1:0] SEL_EXT_MODE  = 2'h2;
   localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;
   // Command code {ras_n, cas_n, we_n} with chip select low
   typedef enum logic [2:0] {
      LPX_CMD_NOP   = 3'h7,
      LPX_CMD_ACT   = 3'h3,
      LPX_CMD_READ  = 3'h5,
      LPX_CMD_WRITE = 3'h4,
      LPX_CMD_PRE   = 3'h2,
      LPX_CMD_REF   = 3'h1,
      LPX_CMD_MODE  = 3'h0,
      LPX_CMD_STOP  = 3'h6
   } lpx_cmd_t;
   // Power state of a die
   typedef enum logic [3:0] {
      LPX_PWR_ON     = 4'h1,
      LPX_PWR_PRE_PD = 4'h2,
      LPX_PWR_ACT_PD = 4'h4,
      LPX_PWR_SREF   = 4'h8
   } lpx_pwr_t;
   // Controller sequencer states
   typedef enum logic [3:0] {
      LPX_H_IDLE = 4'h1,
      LPX_H_ACT  = 4'h2,
      LPX_H_CMD  = 4'h4,
      LPX_H_WAIT = 4'h8
   } lpx_host_st_t;
endpackage
`default_nettype wire

// file: design/lpx_bus_if.sv
// Pin bundle joining controller and memory ends
`default_nettype none
interface lpx_bus_if;
   import lpx_pkg::*;
   logic [DIES-1:0]   clock_enable;
   logic [DIES-1:0]   chip_select_n;
   logic              ras_n;
   logic              cas_n;
   logic              we_n;
   logic [BANK_W-1:0] bank;
   logic [ADDR_W-1:0] addr;
   logic [1:0]        byte_write_mask;
   logic [DATA_W-1:0] dq_h;
   logic              dq_oe_h;
   logic [1:0]        strobe_h;
   logic [DATA_W-1:0] dq_m;
   logic [DIES-1:0]   dq_oe_m;
   logic [1:0]        strobe_m;
   modport host (output clock_enable, chip_select_n, ras_n, cas_n, we_n, bank, addr,
                 byte_write_mask, dq_h, dq_oe_h, strobe_h,
                 input dq_m, dq_oe_m, strobe_m);
   modport mem (input clock_enable, chip_select_n, ras_n, cas_n, we_n, bank, addr,
                byte_write_mask, dq_h, dq_oe_h, strobe_h,
                output dq_m, dq_oe_m, strobe_m);
endinterface
`default_nettype wire

// file: design/lpx_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`default_nettype none
module lpx_fifo
   import lpx_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [PW:0]      count, next_count;
   logic             push, pop;

   // Honest flags from the fill count
   assign in_ready_o  = (count != (PW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Pointer and count update
   always_comb begin
      next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
      next_count  = (PW+1)'(count + {PW'(0), push} - {PW'(0), pop});
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage has no reset; contents are guarded by count
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

// file: design/lpx_host.sv
// Controller end: turns user word requests into pin commands
`default_nettype none
module lpx_host
   import lpx_pkg::*;
(
   input  wire logic              REF_CLK_I,
   input  wire logic              RSTN_I,
   lpx_bus_if.host                bus,
   input  wire logic              REQ_VALID_I,
   output logic                   REQ_READY_O,
   input  wire logic              REQ_WRITE_I,
   input  wire logic              REQ_DIE_I,
   input  wire logic [BANK_W-1:0] REQ_BANK_I,
   input  wire logic [ADDR_W-1:0] REQ_ROW_I,
   input  wire logic [ADDR_W-1:0] REQ_COL_I,
   input  wire logic [DATA_W-1:0] REQ_WDATA_I,
   input  wire logic [1:0]        REQ_MASK_I,
   input  wire logic [DIES-1:0]   SLEEP_I,
   output logic      [DATA_W-1:0] RD_DATA_O,
   output logic                   RD_VALID_O
);
   lpx_host_st_t      st, next_st;
   logic              die, write;
   logic [BANK_W-1:0] bank;
   logic [ADDR_W-1:0] row, col;
   logic [DATA_W-1:0] wdata;
   logic [1:0]        mask;
   logic [3:0]        wait_cnt, next_wait_cnt;
   logic [DATA_W-1:0] rd_data;
   logic              rd_valid;
   logic              take;

   assign REQ_READY_O = (st == LPX_H_IDLE);
   assign take        = REQ_VALID_I && REQ_READY_O;
   assign RD_DATA_O   = rd_data;
   assign RD_VALID_O  = rd_valid;

   // One access at a time; next request only after the burst ends
   always_comb begin
      next_st       = st;
      next_wait_cnt = wait_cnt;
      case (st)
         LPX_H_IDLE: if (take) next_st = LPX_H_ACT;
         LPX_H_ACT:  next_st = LPX_H_CMD;
         LPX_H_CMD: begin
            next_st       = LPX_H_WAIT;
            next_wait_cnt = 4'(CAS_LAT + 2);
         end
         LPX_H_WAIT: begin
            next_wait_cnt = wait_cnt - 4'h1;
            if (wait_cnt == 4'h0) next_st = LPX_H_IDLE;
         end
         default: next_st = LPX_H_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         st <= LPX_H_IDLE;
         wait_cnt <= 4'h0;
         die <= 1'b0;
         write <= 1'b0;
         bank <= '0;
         row <= '0;
         col <= '0;
         wdata <= '0;
         mask <= '0;
         rd_data <= '0;
         rd_valid <= 1'b0;
      end else begin
         st <= next_st;
         wait_cnt <= next_wait_cnt;
         if (take) begin
            die <= REQ_DIE_I;
            write <= REQ_WRITE_I;
            bank <= REQ_BANK_I;
            row <= REQ_ROW_I;
            col <= REQ_COL_I;
            wdata <= REQ_WDATA_I;
            mask <= REQ_MASK_I;
         end
         // Capture the die's answer when it drives the bus
         rd_valid <= |bus.dq_oe_m;
         if (|bus.dq_oe_m) rd_data <= bus.dq_m;
      end
   end

   // Pin drive; clock enable held high while busy
   always_comb begin
      bus.clock_enable  = ~SLEEP_I;
      if (st != LPX_H_IDLE) bus.clock_enable[die] = 1'b1;
      // Wake a sleeping die in the taking cycle so its activate is heard
      if (take) bus.clock_enable[REQ_DIE_I] = 1'b1;
      bus.chip_select_n = '1;
      {bus.ras_n, bus.cas_n, bus.we_n} = LPX_CMD_NOP;
      bus.bank = bank;
      bus.addr = row;
      if (st == LPX_H_ACT) begin
         bus.chip_select_n[die] = 1'b0;
         {bus.ras_n, bus.cas_n, bus.we_n} = LPX_CMD_ACT;
      end else if (st == LPX_H_CMD) begin
         bus.chip_select_n[die] = 1'b0;
         {bus.ras_n, bus.cas_n, bus.we_n} = write ? LPX_CMD_WRITE : LPX_CMD_READ;
         bus.addr = col | (ADDR_W'(1) << AP_BIT); // Auto close keeps banks idle
      end
      // Host owns the bus only for writes with strobe per byte
      bus.dq_oe_h         = (st == LPX_H_CMD) && write;
      bus.dq_h            = wdata;
      bus.strobe_h        = {2{bus.dq_oe_h}};
      bus.byte_write_mask = mask;
   end
endmodule
`default_nettype wire

// file: design/lpx_mem.sv
// Memory end: two dies decoding commands, with read data through a FIFO
// Operation
// - Sample all control on rising clock only
// - Clock enable low stops clocks, buffers, drivers
// - Idle banks: precharge down/self refresh, else active
// - Controller keeps clock enable high during access
// - Power-down ignores inputs except clock, enable
// - Chip select high masks the command
// - Command from select, row, column, write strobes
// - Shared 16-bit two-way data bus
// - Strobes travel with data in both directions
// - Lower strobe bits 0-7, upper 8-15
// - Masked write beats are not stored
// - Write masks ignored during reads
// - Lower mask bits 0-7, upper 8-15
// - Bank select picks bank for commands
// - Bank select picks base or extended mode
// - Row on activate, column plus flag otherwise
// - Address bit ten closes one or all
// - Mode load takes opcode from address
// - Each die answers only its select
// - Other die accessed after burst completes
`default_nettype none
module lpx_mem
   import lpx_pkg::*;
#(
   parameter int WORDS = MEM_WORDS
) (
   input  wire logic                REF_CLK_I,
   input  wire logic                RSTN_I,
   lpx_bus_if.mem                   bus,
   output logic [DIES*BANKS-1:0]    BANK_OPEN_O,
   output logic [DIES*4-1:0]        POWER_STATE_O,
   output logic [DIES*ADDR_W-1:0]   BASE_MODE_O,
   output logic [DIES*ADDR_W-1:0]   EXT_MODE_O
);
   localparam int IW = $clog2(WORDS);
   logic [DATA_W-1:0] store [DIES][WORDS];
   logic [BANKS-1:0]  open_bank [DIES];
   logic [BANKS-1:0]  next_open [DIES];
   lpx_pwr_t          pwr [DIES];
   lpx_pwr_t          next_pwr [DIES];
   logic [ADDR_W-1:0] base_mode [DIES];
   logic [ADDR_W-1:0] next_base_mode [DIES];
   logic [ADDR_W-1:0] ext_mode [DIES];
   logic [ADDR_W-1:0] next_ext_mode [DIES];
   logic [ADDR_W-1:0] row [DIES][BANKS];
   logic [ADDR_W-1:0] next_row [DIES][BANKS];
   logic [DIES-1:0]   cke_q;
   logic [DIES-1:0]   live;
   logic [DIES-1:0]   hit;
   logic [DIES-1:0]   wr_hit;
   logic [1:0]        lane_en;
   lpx_cmd_t          cmd;
   logic              rd_req;
   logic              rd_die, next_rd_die;
   logic [IW-1:0]     rd_idx;
   logic [DATA_W:0]   f_in, f_out;
   logic              f_valid, f_in_ready;
   logic              send;

   // Command code from the three strobes
   assign cmd = lpx_cmd_t'({bus.ras_n, bus.cas_n, bus.we_n});

   // A die listens only with its enable high and not powered down
   always_comb begin
      for (int d = 0; d < DIES; d++) begin
         live[d] = bus.clock_enable[d] && cke_q[d] && !bus.chip_select_n[d];
         // Column commands reach only a bank that an activate opened
         hit[d]  = live[d] && open_bank[d][bus.bank];
      end
   end

   // Power and bank state per die
   always_comb begin
      for (int d = 0; d < DIES; d++) begin
         next_open[d] = open_bank[d];
         next_pwr[d]  = pwr[d];
         if (!bus.clock_enable[d] && pwr[d] == LPX_PWR_ON) begin
            // Entry mode follows the bank state
            if (open_bank[d] != '0) next_pwr[d] = LPX_PWR_ACT_PD;
            else if (!bus.chip_select_n[d] && cmd == LPX_CMD_REF) next_pwr[d] = LPX_PWR_SREF;
            else next_pwr[d] = LPX_PWR_PRE_PD;
         end else if (bus.clock_enable[d]) begin
            next_pwr[d] = LPX_PWR_ON;
         end
         if (live[d]) begin
            if (cmd == LPX_CMD_ACT) begin
               next_open[d][bus.bank] = 1'b1;
            end else if (cmd == LPX_CMD_PRE) begin
               if (bus.addr[AP_BIT]) next_open[d] = '0;
               else next_open[d][bus.bank] = 1'b0;
            end else if ((cmd == LPX_CMD_READ || cmd == LPX_CMD_WRITE) && bus.addr[AP_BIT]) begin
               next_open[d][bus.bank] = 1'b0;
            end
         end
      end
   end

   // Row and mode registers; a load lands only on a listening die
   always_comb begin
      for (int d = 0; d < DIES; d++) begin
         next_base_mode[d] = base_mode[d];
         next_ext_mode[d]  = ext_mode[d];
         for (int b = 0; b < BANKS; b++) next_row[d][b] = row[d][b];
         if (live[d] && cmd == LPX_CMD_ACT) next_row[d][bus.bank] = bus.addr;
         if (live[d] && cmd == LPX_CMD_MODE) begin
            if (bus.bank == SEL_BASE_MODE) next_base_mode[d] = bus.addr;
            else if (bus.bank == SEL_EXT_MODE) next_ext_mode[d] = bus.addr;
         end
      end
   end

   // Read request picks the live die with an open bank
   always_comb begin
      rd_req      = 1'b0;
      next_rd_die = 1'b0;
      for (int d = 0; d < DIES; d++) begin
         if (hit[d] && cmd == LPX_CMD_READ) begin
            rd_req      = 1'b1;
            next_rd_die = 1'(d);
         end
      end
      rd_die = next_rd_die;
      rd_idx = IW'(bus.addr);
      f_in   = {rd_die, store[rd_die][rd_idx]};
   end

   // All sampling on the rising edge only
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cke_q    <= '0;
         for (int d = 0; d < DIES; d++) begin
            open_bank[d] <= '0;
            pwr[d]       <= LPX_PWR_PRE_PD;
            base_mode[d] <= MODE_RESET;
            ext_mode[d]  <= MODE_RESET;
            for (int b = 0; b < BANKS; b++) row[d][b] <= '0;
         end
      end else begin
         cke_q    <= bus.clock_enable;
         for (int d = 0; d < DIES; d++) begin
            open_bank[d] <= next_open[d];
            pwr[d]       <= next_pwr[d];
            base_mode[d] <= next_base_mode[d];
            ext_mode[d]  <= next_ext_mode[d];
            for (int b = 0; b < BANKS; b++) row[d][b] <= next_row[d][b];
         end
      end
   end

   // Byte lanes a write may touch; each lane gated by its own mask
   always_comb begin
      for (int d = 0; d < DIES; d++) begin
         wr_hit[d] = hit[d] && cmd == LPX_CMD_WRITE && bus.dq_oe_h;
      end
      for (int b = 0; b < 2; b++) begin
         lane_en[b] = bus.strobe_h[b] && !bus.byte_write_mask[b];
      end
   end

   // Storage has no reset; a word read before its first write is unknown
   always_ff @(posedge REF_CLK_I) begin
      for (int d = 0; d < DIES; d++) begin
         for (int b = 0; b < 2; b++) begin
            if (wr_hit[d] && lane_en[b]) begin
               store[d][IW'(bus.addr)][b*BYTE_W +: BYTE_W] <= bus.dq_h[b*BYTE_W +: BYTE_W];
            end
         end
      end
   end

   // Read words queue here; masks never reach this path
   // A read arriving with the queue full is dropped, the pins never stall
   lpx_fifo #(
      .WIDTH (DATA_W + 1),
      .DEPTH (FIFO_DEPTH)
   ) u_rd_fifo (
      .clk_i       (REF_CLK_I),
      .rst_n_i     (RSTN_I),
      .in_data_i   (f_in),
      .in_valid_i  (rd_req && f_in_ready),
      .in_ready_o  (f_in_ready),
      .out_data_o  (f_out),
      .out_valid_o (f_valid),
      .out_ready_i (send)
   );

   // Drain only while that die's drivers are on; overflow drops are silent, no flag shows them
   assign send = f_valid && bus.clock_enable[f_out[DATA_W]];

   // Drive bus only while returning data, otherwise released
   always_comb begin
      bus.dq_oe_m = '0;
      if (send) bus.dq_oe_m[f_out[DATA_W]] = 1'b1;
      bus.dq_m     = f_out[DATA_W-1:0];
      bus.strobe_m = {2{send}};
   end

   // Status views
   always_comb begin
      for (int d = 0; d < DIES; d++) begin
         BANK_OPEN_O[d*BANKS +: BANKS]    = open_bank[d];
         POWER_STATE_O[d*4 +: 4]          = pwr[d];
         BASE_MODE_O[d*ADDR_W +: ADDR_W]  = base_mode[d];
         EXT_MODE_O[d*ADDR_W +: ADDR_W]   = ext_mode[d];
      end
   end
endmodule
`default_nettype wire

// file: testbench/lpx_pin_checker.sv
// Concurrent checks on the pins between controller and memory ends
`default_nettype none
module lpx_pin_checker
   import lpx_pkg::*;
(
   input  wire logic              REF_CLK_I,
   input  wire logic              RSTN_I,
   input  wire logic [DIES-1:0]   clock_enable,
   input  wire logic [DIES-1:0]   chip_select_n,
   input  wire logic              ras_n,
   input  wire logic              cas_n,
   input  wire logic              we_n,
   input  wire logic [BANK_W-1:0] bank,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [1:0]        byte_write_mask,
   input  wire logic [DATA_W-1:0] dq_h,
   input  wire logic              dq_oe_h,
   input  wire logic [1:0]        strobe_h,
   input  wire logic [DATA_W-1:0] dq_m,
   input  wire logic [DIES-1:0]   dq_oe_m,
   input  wire logic [1:0]        strobe_m
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);
   logic [2:0]      cmd;
   logic [DIES-1:0] rd;
   logic [DIES-1:0] wr;
   logic [DIES-1:0] act;
   // Per-die decode as each die sees it; select gates the code
   always_comb begin
      cmd = {ras_n, cas_n, we_n};
      for (int d = 0; d < DIES; d++) begin
         rd[d]  = !chip_select_n[d] && cmd == LPX_CMD_READ;
         wr[d]  = !chip_select_n[d] && cmd == LPX_CMD_WRITE;
         act[d] = !chip_select_n[d] && cmd == LPX_CMD_ACT;
      end
   end
   AST_ONE_BUS_DRIVER: assert property (!(dq_oe_h && (|dq_oe_m)))
      else $error("controller and memory drive data together");
   AST_ONE_DIE_DRIVES: assert property (!(&dq_oe_m))
      else $error("both dies drive data together");
   AST_READ_STROBES: assert property ((|dq_oe_m) |-> strobe_m == 2'h3)
      else $error("read data without both strobes");
   AST_WRITE_DATA: assert property (dq_oe_h == (|wr) && (!dq_oe_h || strobe_h == 2'h3))
      else $error("write data not tied to write command");
   AST_READ_ANSWER: assert property (rd[0] && clock_enable[0] && $past(clock_enable[0])
      |=> dq_oe_m[0])
      else $error("die 0 did not answer its read");
   AST_DRIVE_CAUSE: assert property ($rose(dq_oe_m[1]) |-> $past(rd[1]))
      else $error("die 1 drove data without its own read");
   AST_CKE_HELD: assert property ((|(rd | wr)) |-> ((rd | wr) & ~clock_enable) == 2'h0)
      else $error("access issued with clock enable low");
   AST_ACT_THEN_ACCESS: assert property ((|act) |=> (rd | wr) == $past(act)
      && $stable(bank) && addr[AP_BIT])
      else $error("activate not followed by access to same bank");
   AST_IDLE_RELEASE: assert property ((|dq_oe_m) |=> dq_oe_m == 2'h0 [*2])
      else $error("memory kept driving after its word");
   cover property (|rd);
   cover property (|wr);
   cover property ($fell(clock_enable[1]));
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench joining controller and memory ends
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
   import lpx_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic                    clk;
   logic                    rst_n;
   logic                    req_valid;
   logic                    req_ready;
   logic                    req_write;
   logic                    req_die;
   logic [BANK_W-1:0]       req_bank;
   logic [ADDR_W-1:0]       req_row;
   logic [ADDR_W-1:0]       req_col;
   logic [DATA_W-1:0]       req_wdata;
   logic [1:0]              req_mask;
   logic [DIES-1:0]         sleep;
   logic [DATA_W-1:0]       rd_data;
   logic                    rd_valid;
   logic [DIES*BANKS-1:0]   bank_open;
   logic [DIES*4-1:0]       power_state;
   logic [DIES*ADDR_W-1:0]  base_mode;
   logic [DIES*ADDR_W-1:0]  ext_mode;
   logic [DATA_W-1:0]       mdl [DIES][MEM_WORDS];
   logic [DATA_W-1:0]       exp_q [$];
   logic [DATA_W-1:0]       exp_w;
   int                      err_total;
   int                      n_compared;
   int                      cyc;

   lpx_bus_if lpx_bus_if_inst ();
   lpx_host lpx_host_inst (.REF_CLK_I(clk), .RSTN_I(rst_n), .bus(lpx_bus_if_inst.host),
      .REQ_VALID_I(req_valid), .REQ_READY_O(req_ready), .REQ_WRITE_I(req_write),
      .REQ_DIE_I(req_die), .REQ_BANK_I(req_bank), .REQ_ROW_I(req_row), .REQ_COL_I(req_col),
      .REQ_WDATA_I(req_wdata), .REQ_MASK_I(req_mask), .SLEEP_I(sleep),
      .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid));
   lpx_mem lpx_mem_inst (.REF_CLK_I(clk), .RSTN_I(rst_n), .bus(lpx_bus_if_inst.mem),
      .BANK_OPEN_O(bank_open), .POWER_STATE_O(power_state),
      .BASE_MODE_O(base_mode), .EXT_MODE_O(ext_mode));
   lpx_pin_checker lpx_pin_checker_inst (.REF_CLK_I(clk), .RSTN_I(rst_n),
      .clock_enable(lpx_bus_if_inst.clock_enable), .chip_select_n(lpx_bus_if_inst.chip_select_n),
      .ras_n(lpx_bus_if_inst.ras_n), .cas_n(lpx_bus_if_inst.cas_n), .we_n(lpx_bus_if_inst.we_n),
      .bank(lpx_bus_if_inst.bank), .addr(lpx_bus_if_inst.addr),
      .byte_write_mask(lpx_bus_if_inst.byte_write_mask), .dq_h(lpx_bus_if_inst.dq_h),
      .dq_oe_h(lpx_bus_if_inst.dq_oe_h), .strobe_h(lpx_bus_if_inst.strobe_h),
      .dq_m(lpx_bus_if_inst.dq_m), .dq_oe_m(lpx_bus_if_inst.dq_oe_m),
      .strobe_m(lpx_bus_if_inst.strobe_m));

   // Free-running 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Verdict and end of run, shared with the hang guard
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // One word request; model updated at the taking edge, bytes kept where masked
   task automatic access(input logic w, input logic d, input logic [5:0] col,
                         input logic [15:0] data, input logic [1:0] m);
      int k;
      @(negedge clk);
      req_valid = 1'b1;
      req_write = w;
      req_die   = d;
      req_bank  = 2'($urandom);
      req_row   = 13'($urandom);
      req_col   = {7'($urandom), col};
      req_wdata = data;
      req_mask  = m;
      k = 0;
      while (req_ready !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
      @(posedge clk);
      if (w) mdl[d][col] = {m[1] ? mdl[d][col][15:8] : data[15:8],
                            m[0] ? mdl[d][col][7:0] : data[7:0]};
      else exp_q.push_back(mdl[d][col]);
      @(negedge clk);
      req_valid = 1'b0;
   endtask

   // Returned words against the model, in request order, looked at mid-cycle
   always @(negedge clk) begin
      if (rst_n && rd_valid === 1'b1) begin
         exp_w = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
         `CHK(rd_data, exp_w)
      end
   end

   // Hang guard, far above the thousand or so cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         err_total++;
         test_done();
      end
   end

   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_die = 1'b0;
      req_bank = 2'h0;
      req_row = 13'h0000;
      req_col = 13'h0000;
      req_wdata = 16'h0000;
      req_mask = 2'h0;
      sleep = 2'h0;
      err_total = 0;
      n_compared = 0;
      cyc = 0;
      void'($urandom(46));
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      `CHK(bank_open, 8'h00)
      `CHK(base_mode, {DIES{MODE_RESET}})
      `CHK(ext_mode, {DIES{MODE_RESET}})
      repeat (3) @(negedge clk);
      `CHK(power_state, 8'h11)
      // Fill both dies, boundary columns included, then read back with stray masks
      for (int d = 0; d < DIES; d++) for (int c = 0; c < 8; c++) begin
         access(1'b1, 1'(d), 6'(c * 9), 16'($urandom), 2'h0);
      end
      for (int d = 0; d < DIES; d++) for (int c = 0; c < 8; c++) begin
         access(1'b0, 1'(d), 6'(c * 9), 16'h0000, 2'($urandom));
      end
      $display("fill test done");
      // Every mask code on each die
      for (int d = 0; d < DIES; d++) for (int m = 0; m < 4; m++) begin
         access(1'b1, 1'(d), 6'h3f, 16'($urandom), 2'(m));
         access(1'b0, 1'(d), 6'h3f, 16'h0000, 2'h3);
      end
      $display("mask test done");
      // Random mix, die picked at random for each access, back to back
      repeat (60) begin
         access(1'($urandom), 1'($urandom), 6'(($urandom % 8) * 9), 16'($urandom), 2'($urandom));
      end
      // Let the last access finish before looking at idle state
      repeat (12) @(negedge clk);
      `CHK(bank_open, 8'h00)
      `CHK(lpx_bus_if_inst.dq_oe_m, 2'h0)
      $display("random test done");
      // Die 1 asleep while die 0 keeps working
      sleep = 2'h2;
      repeat (4) @(negedge clk);
      `CHK(lpx_bus_if_inst.clock_enable, 2'h1)
      `CHK(power_state[7:4], 4'h2)
      access(1'b1, 1'b0, 6'h00, 16'($urandom), 2'h0);
      access(1'b0, 1'b0, 6'h00, 16'h0000, 2'h0);
      `CHK(power_state[7:4], 4'h2)
      // A read to the sleeping die must wake it for the whole access
      access(1'b0, 1'b1, 6'h12, 16'h0000, 2'h0);
      repeat (12) @(negedge clk);
      `CHK(exp_q.size(), 0)
      `CHK(power_state[7:4], 4'h2)
      @(negedge clk);
      sleep = 2'h0;
      repeat (3) @(negedge clk);
      `CHK(power_state, 8'h11)
      access(1'b0, 1'b1, 6'h09, 16'h0000, 2'h1);
      repeat (12) @(negedge clk);
      `CHK(exp_q.size(), 0)
      $display("sleep test done");
      test_done();
   end
endmodule
`default_nettype wire
